// ===== sodr_pkg.sv
// Package holding the register map, field positions and reset values of the output divider register bank.
package sodr_pkg;

	// Register count and the byte address of the first register.
	localparam int SODR_NUM_REGS = 12;
	localparam logic [7:0] SODR_BASE_ADDR = 8'h15;

	// Register byte addresses.
	localparam logic [7:0] SODR_ADDR_OUTPUT_DRIVER_CONTROL = 8'h15;
	localparam logic [7:0] SODR_ADDR_OUTPUT_DIVIDER_HIGH = 8'h16;
	localparam logic [7:0] SODR_ADDR_OUTPUT_DIVIDER_LOW = 8'h17;
	localparam logic [7:0] SODR_ADDR_REFERENCE_DIVIDER_CONTROL = 8'h18;
	localparam logic [7:0] SODR_ADDR_FEEDBACK_INTEGER_HIGH = 8'h19;
	localparam logic [7:0] SODR_ADDR_FEEDBACK_INTEGER_LOW = 8'h1A;
	localparam logic [7:0] SODR_ADDR_FRACTION_NUMERATOR_TOP = 8'h1B;
	localparam logic [7:0] SODR_ADDR_FRACTION_NUMERATOR_MID = 8'h1C;
	localparam logic [7:0] SODR_ADDR_FRACTION_NUMERATOR_LOW = 8'h1D;
	localparam logic [7:0] SODR_ADDR_FRACTION_DENOMINATOR_TOP = 8'h1E;
	localparam logic [7:0] SODR_ADDR_FRACTION_DENOMINATOR_MID = 8'h1F;
	localparam logic [7:0] SODR_ADDR_FRACTION_DENOMINATOR_LOW = 8'h20;

	// Register indices within the bank.
	localparam int SODR_IDX_DRV = 0;
	localparam int SODR_IDX_ODIV_HI = 1;
	localparam int SODR_IDX_ODIV_LO = 2;
	localparam int SODR_IDX_RDIV = 3;
	localparam int SODR_IDX_NDIV_HI = 4;
	localparam int SODR_IDX_NDIV_LO = 5;
	localparam int SODR_IDX_NUM_TOP = 6;
	localparam int SODR_IDX_NUM_MID = 7;
	localparam int SODR_IDX_NUM_LOW = 8;
	localparam int SODR_IDX_DEN_TOP = 9;
	localparam int SODR_IDX_DEN_MID = 10;
	localparam int SODR_IDX_DEN_LOW = 11;

	// Field positions.
	localparam int SODR_POS_POWERDOWN = 7;
	localparam int SODR_POS_DRV_SEL_HI = 1;
	localparam int SODR_POS_DRV_SEL_LO = 0;
	localparam int SODR_POS_ODIV_BIT8 = 0;
	localparam int SODR_POS_RDIV4 = 0;

	// Reset values, indexed as above.
	localparam logic [7:0] SODR_RESET [SODR_NUM_REGS] = '{
		8'h02, 8'h00, 8'h4E, 8'h01, 8'h00, 8'hDC,
		8'h1C, 8'hB3, 8'hE3, 8'h3F, 8'hFF, 8'hFF
	};

	// Writable bits; reserved bits stay zero and read as zero.
	localparam logic [7:0] SODR_MASK [SODR_NUM_REGS] = '{
		8'h83, 8'h01, 8'hFF, 8'h01, 8'h0F, 8'hFF,
		8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF
	};

	// Divider widths and limits.
	localparam int SODR_ODIV_W = 9;
	localparam logic [8:0] SODR_ODIV_MIN = 9'h005;
	localparam int SODR_RDIV_W = 3;
	localparam logic [2:0] SODR_RDIV_FOUR = 3'h4;
	localparam logic [2:0] SODR_RDIV_ONE = 3'h1;
	localparam int SODR_NDIV_W = 12;
	localparam int SODR_FRAC_W = 22;

	// Output driver stage selection, in the order of the select field codes.
	typedef enum logic [1:0] {
		SODR_DRV_TRISTATE,
		SODR_DRV_LVPECL,
		SODR_DRV_LVDS,
		SODR_DRV_HCSL
	} sodr_drv_t;

endpackage

// ===== sodr_int_divider.sv
// Integer tick divider used for the output divider and the reference divider.
`timescale 1ns/100ps
`default_nettype none
module sodr_int_divider #(
	parameter int W = 9,
	parameter logic [W-1:0] MIN_DIV = W'(1)
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick_in,
	input wire logic [W-1:0] divide_by,
	output logic tick_out
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_tick_out;
	logic [W-1:0] eff_div;

	// Values below the floor are reserved; clamping keeps the counter sane if software slips.
	always_comb begin
		eff_div = (divide_by < MIN_DIV) ? MIN_DIV : divide_by;
		next_count = count;
		next_tick_out = 1'b0;
		if (tick_in) begin
			if (count >= eff_div - W'(1)) begin
				next_count = '0;
				next_tick_out = 1'b1;
			end else begin
				next_count = count + W'(1);
			end
		end
	end

	// Counter and output pulse registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			count <= next_count;
			tick_out <= next_tick_out;
		end
	end

endmodule
`default_nettype wire

// ===== sodr_regs.sv
// Configuration register bank for the synthesizer output, reference, feedback and fraction settings.
// Operation
// - two-bit select picks tristate, LVPECL, LVDS, HCSL
// - bit seven powers down output buffer
// - nine-bit output divider, values five to 511
// - divider bit eight plus next full byte
// - reference divider divides by four or bypasses
// - twelve-bit feedback integer from nibble and byte
// - 22-bit numerator from six bits, two bytes
// - 22-bit denominator top six bits, middle byte
// - lowest denominator byte follows, resets all ones
`timescale 1ns/100ps
`default_nettype none
module sodr_regs
	import sodr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic vco_tick,
	input wire logic ref_tick,
	output logic out_tick,
	output logic pfd_tick,
	output logic output_buffer_powerdown,
	output logic [1:0] driver_select,
	output logic out_tristate,
	output logic out_lvpecl_en,
	output logic out_lvds_en,
	output logic out_hcsl_en,
	output logic [SODR_ODIV_W-1:0] output_divider_value,
	output logic reference_div4_enable,
	output logic [SODR_NDIV_W-1:0] feedback_integer_value,
	output logic [SODR_FRAC_W-1:0] fraction_numerator,
	output logic [SODR_FRAC_W-1:0] fraction_denominator
);

	// Stored bytes and their next values, one entry per register.
	logic [7:0] regs [SODR_NUM_REGS];
	logic [7:0] next_regs [SODR_NUM_REGS];

	// Applied numerator and read path.
	logic [SODR_FRAC_W-1:0] next_fraction_numerator;
	logic num_low_hit;
	logic [7:0] next_reg_rdata;
	logic next_reg_rvalid;

	// Decode helpers.
	logic [7:0] drv_byte;
	logic [2:0] ref_divide_by;
	sodr_drv_t drv_mode;

	// Register map, byte addresses and what each holds:
	// 0x15 output driver control: bit 7 buffer powerdown, bits 1:0 driver select.
	// 0x16 output divider high: bit 0 is divider bit 8.
	// 0x17 output divider low: divider bits 7:0.
	// 0x18 reference divider control: bit 0 enables divide by four.
	// 0x19 feedback integer high: bits 3:0 are feedback bits 11:8.
	// 0x1A feedback integer low: feedback bits 7:0.
	// 0x1B fraction numerator top: bits 5:0 are numerator bits 21:16.
	// 0x1C fraction numerator middle: numerator bits 15:8.
	// 0x1D fraction numerator low: numerator bits 7:0, and the write that applies all three.
	// 0x1E fraction denominator top: bits 5:0 are denominator bits 21:16.
	// 0x1F fraction denominator middle: denominator bits 15:8.
	// 0x20 fraction denominator low: denominator bits 7:0.
	// Reserved bits are not stored, so they read back as zero whatever was written.

	// One flip-flop byte per register; a write stores only the defined bits of the addressed entry.
	// Back-to-back writes are taken every cycle; there is no busy state to wait for.
	for (genvar i = 0; i < SODR_NUM_REGS; i++) begin : g_reg
		always_comb begin
			next_regs[i] = regs[i];
			if (reg_wr && reg_addr == SODR_BASE_ADDR + 8'(i)) begin
				next_regs[i] = reg_wdata & SODR_MASK[i];
			end
		end

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				regs[i] <= SODR_RESET[i];
			end else begin
				regs[i] <= next_regs[i];
			end
		end
	end

	// The applied numerator moves only when its low byte is written, so a top-first update lands at once.
	// Trade-off: a host that writes only the low byte applies it with the stored top and middle bytes,
	// and top or middle bytes written alone read back without changing the applied fraction.
	always_comb begin
		num_low_hit = reg_wr && reg_addr == SODR_ADDR_FRACTION_NUMERATOR_LOW;
		next_fraction_numerator = fraction_numerator;
		if (num_low_hit) begin
			next_fraction_numerator = {regs[SODR_IDX_NUM_TOP][5:0], regs[SODR_IDX_NUM_MID], reg_wdata};
		end
	end

	// Applied numerator register.
	// Its reset value matches the stored bytes after reset, so the two views agree.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fraction_numerator <= {SODR_RESET[SODR_IDX_NUM_TOP][5:0], SODR_RESET[SODR_IDX_NUM_MID],
				SODR_RESET[SODR_IDX_NUM_LOW]};
		end else begin
			fraction_numerator <= next_fraction_numerator;
		end
	end

	// Read path answers one cycle after the strobe; unmapped addresses read as zero.
	// A read in the same cycle as a write to that address returns the old value.
	always_comb begin
		next_reg_rdata = reg_rdata;
		next_reg_rvalid = reg_rd;
		if (reg_rd) begin
			next_reg_rdata = 8'h00;
			case (reg_addr)
				SODR_ADDR_OUTPUT_DRIVER_CONTROL: next_reg_rdata = regs[SODR_IDX_DRV];
				SODR_ADDR_OUTPUT_DIVIDER_HIGH: next_reg_rdata = regs[SODR_IDX_ODIV_HI];
				SODR_ADDR_OUTPUT_DIVIDER_LOW: next_reg_rdata = regs[SODR_IDX_ODIV_LO];
				SODR_ADDR_REFERENCE_DIVIDER_CONTROL: next_reg_rdata = regs[SODR_IDX_RDIV];
				SODR_ADDR_FEEDBACK_INTEGER_HIGH: next_reg_rdata = regs[SODR_IDX_NDIV_HI];
				SODR_ADDR_FEEDBACK_INTEGER_LOW: next_reg_rdata = regs[SODR_IDX_NDIV_LO];
				SODR_ADDR_FRACTION_NUMERATOR_TOP: next_reg_rdata = regs[SODR_IDX_NUM_TOP];
				SODR_ADDR_FRACTION_NUMERATOR_MID: next_reg_rdata = regs[SODR_IDX_NUM_MID];
				SODR_ADDR_FRACTION_NUMERATOR_LOW: next_reg_rdata = regs[SODR_IDX_NUM_LOW];
				SODR_ADDR_FRACTION_DENOMINATOR_TOP: next_reg_rdata = regs[SODR_IDX_DEN_TOP];
				SODR_ADDR_FRACTION_DENOMINATOR_MID: next_reg_rdata = regs[SODR_IDX_DEN_MID];
				SODR_ADDR_FRACTION_DENOMINATOR_LOW: next_reg_rdata = regs[SODR_IDX_DEN_LOW];
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	// Read data and valid registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end

	// Driver control byte views; these are flip-flop outputs passed straight through.
	always_comb begin
		drv_byte = regs[SODR_IDX_DRV];
		output_buffer_powerdown = drv_byte[SODR_POS_POWERDOWN];
		driver_select = drv_byte[SODR_POS_DRV_SEL_HI:SODR_POS_DRV_SEL_LO];
	end

	// Divider views; the output divider spans two bytes, so between the two writes it holds a mixed value.
	always_comb begin
		output_divider_value = {regs[SODR_IDX_ODIV_HI][SODR_POS_ODIV_BIT8], regs[SODR_IDX_ODIV_LO]};
		reference_div4_enable = regs[SODR_IDX_RDIV][SODR_POS_RDIV4];
		feedback_integer_value = {regs[SODR_IDX_NDIV_HI][3:0], regs[SODR_IDX_NDIV_LO]};
	end

	// Denominator view; unlike the numerator it has no shadow, so it follows each byte as written.
	always_comb begin
		fraction_denominator = {regs[SODR_IDX_DEN_TOP][5:0], regs[SODR_IDX_DEN_MID],
			regs[SODR_IDX_DEN_LOW]};
	end

	// Driver stage decode; powerdown forces every stage off and the pin floats.
	// Tri-state is its own flag so the pad logic need not decode the select field again.
	always_comb begin
		drv_mode = sodr_drv_t'(driver_select);
		out_tristate = 1'b0;
		out_lvpecl_en = 1'b0;
		out_lvds_en = 1'b0;
		out_hcsl_en = 1'b0;
		case (drv_mode)
			SODR_DRV_TRISTATE: out_tristate = 1'b1;
			SODR_DRV_LVPECL: out_lvpecl_en = !output_buffer_powerdown;
			SODR_DRV_LVDS: out_lvds_en = !output_buffer_powerdown;
			SODR_DRV_HCSL: out_hcsl_en = !output_buffer_powerdown;
			default: out_tristate = 1'b1;
		endcase
		if (output_buffer_powerdown) begin
			out_tristate = 1'b1;
		end
	end

	// Reference divider: four when the control bit is set, else a straight bypass.
	// Bypass still passes through one register stage, so the comparison tick lags the reference by a cycle.
	always_comb begin
		ref_divide_by = reference_div4_enable ? SODR_RDIV_FOUR : SODR_RDIV_ONE;
	end

	// Reference divider instance; a floor of one lets the bypass setting pass every tick.
	sodr_int_divider #(
		.W(SODR_RDIV_W),
		.MIN_DIV(SODR_RDIV_ONE)
	) u_ref_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_in(ref_tick),
		.divide_by(ref_divide_by),
		.tick_out(pfd_tick)
	);

	// Output divider; reserved settings below five are treated as five.
	// The counter does not restart on a new setting, so the first period after a change may be short.
	sodr_int_divider #(
		.W(SODR_ODIV_W),
		.MIN_DIV(SODR_ODIV_MIN)
	) u_out_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_in(vco_tick),
		.divide_by(output_divider_value),
		.tick_out(out_tick)
	);

endmodule
`default_nettype wire

// ===== sodr_regs_asserts.sv
// Checker of the output divider register bank port behaviour.
`timescale 1ns/100ps
`default_nettype none
module sodr_regs_asserts(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic output_buffer_powerdown,
	input wire logic [1:0] driver_select,
	input wire logic out_lvds_en,
	input wire logic [8:0] output_divider_value,
	input wire logic reference_div4_enable,
	input wire logic [11:0] feedback_integer_value,
	input wire logic [21:0] fraction_numerator,
	input wire logic [21:0] fraction_denominator
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [7:0] wa;
	// Address of the write taken this cycle; zero never matches a mapped register.
	assign wa = reg_wr ? reg_addr : 8'h00;
	property p_sel; wa == 8'h15 |=> driver_select == $past(reg_wdata[1:0]); endproperty
	a_sel: assert property (p_sel) else $error("select not stored");
	property p_lvds; out_lvds_en == (driver_select == 2'h2 && !output_buffer_powerdown); endproperty
	a_lvds: assert property (p_lvds) else $error("lvds enable wrong");
	property p_pd; wa == 8'h15 |=> output_buffer_powerdown == $past(reg_wdata[7]); endproperty
	a_pd: assert property (p_pd) else $error("powerdown not stored");
	property p_odl; wa == 8'h17 |=> output_divider_value[7:0] == $past(reg_wdata); endproperty
	a_odl: assert property (p_odl) else $error("divider low wrong");
	property p_rdiv; wa == 8'h18 |=> reference_div4_enable == $past(reg_wdata[0]); endproperty
	a_rdiv: assert property (p_rdiv) else $error("reference bit wrong");
	property p_ndiv; wa == 8'h19 |=> feedback_integer_value[11:8] == $past(reg_wdata[3:0]); endproperty
	a_ndiv: assert property (p_ndiv) else $error("feedback high wrong");
	property p_num; wa == 8'h1D |=> fraction_numerator[7:0] == $past(reg_wdata); endproperty
	a_num: assert property (p_num) else $error("numerator low wrong");
	property p_den; wa == 8'h1E |=> fraction_denominator[21:16] == $past(reg_wdata[5:0]); endproperty
	a_den: assert property (p_den) else $error("denominator top wrong");
	// Main scenarios seen.
	c_num: cover property (wa == 8'h1D);
	c_pd: cover property (output_buffer_powerdown);
	c_lvds: cover property (out_lvds_en);
endmodule
`default_nettype wire

// ===== sodr_host_model.sv
// Host model issuing register accesses to the bank.
`timescale 1ns/100ps
`default_nettype none
module sodr_host_model(
	input wire logic clk_sys,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Idle bus at time zero.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Held across the taking edge, then released with the inverse so stale data never looks valid.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Numerator goes top byte first so no intermediate fraction is applied.
	task automatic num(input logic [21:0] v);
		acc(1'b1, 8'h1B, {2'h0, v[21:16]});
		acc(1'b1, 8'h1C, v[15:8]);
		acc(1'b1, 8'h1D, v[7:0]);
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the output divider register bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import sodr_pkg::*;
	logic clk_sys, rst_n, reg_wr, reg_rd, vco_tick, ref_tick, reg_rvalid, out_tick, pfd_tick, pd, pecl, lvds, hcsl, tri_s, r4;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [7:0] v [SODR_NUM_REGS];
	logic [1:0] sel;
	logic [8:0] odiv;
	logic [11:0] ndiv;
	logic [21:0] num, den;
	logic [7:0] exp_q[$];
	int bad_count = 0, tests_run = 0, cyc = 0, n_out = 0, n_pfd = 0, o0 = 0, p0 = 0;
	sodr_host_model host(.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	sodr_regs DUT(.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vco_tick(vco_tick),
		.ref_tick(ref_tick), .out_tick(out_tick), .pfd_tick(pfd_tick), .output_buffer_powerdown(pd),
		.driver_select(sel), .out_tristate(tri_s), .out_lvpecl_en(pecl), .out_lvds_en(lvds), .out_hcsl_en(hcsl),
		.output_divider_value(odiv), .reference_div4_enable(r4), .feedback_integer_value(ndiv),
		.fraction_numerator(num), .fraction_denominator(den));
	// Clock at 25 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %0t got %0h want %0h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.acc(1'b0, a, 8'h00);
	endtask
	task automatic results;
		cmp(exp_q.size(), 0);
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watcher: pairs each read answer with the oldest note, counts tick pulses, cuts a hang short.
	always @(negedge clk_sys) begin
		cyc++;
		n_out += int'(out_tick === 1'b1);
		n_pfd += int'(pfd_tick === 1'b1);
		if (reg_rvalid === 1'b1)
			cmp(reg_rdata, exp_q.pop_front());
		if (cyc > 3000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		vco_tick = 1'b0;
		ref_tick = 1'b0;
		void'($urandom(36990));
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		// Dividers count from reset: 160 ticks give 40 reference and 2 output pulses.
		vco_tick = 1'b1;
		ref_tick = 1'b1;
		repeat (160) @(negedge clk_sys);
		vco_tick = 1'b0;
		ref_tick = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp(n_pfd, 40);
		cmp(n_out, 2);
		$display("end of test ticks");
		for (int i = 0; i < SODR_NUM_REGS; i++)
			rd(SODR_BASE_ADDR + 8'(i), SODR_RESET[i]);
		rd(8'h14, 8'h00);
		rd(8'h21, 8'h00);
		$display("end of test reset values");
		// Random data, output divider kept at 8 or more.
		for (int i = 0; i < SODR_NUM_REGS; i++) begin
			d = 8'($urandom) | ((i == 2) ? 8'h08 : 8'h00);
			v[i] = d & SODR_MASK[i];
			host.acc(1'b1, SODR_BASE_ADDR + 8'(i), d);
			rd(SODR_BASE_ADDR + 8'(i), v[i]);
		end
		cmp(odiv, {v[1][0], v[2]});
		cmp(r4, v[3][0]);
		cmp(ndiv, {v[4][3:0], v[5]});
		cmp(den, {v[9][5:0], v[10], v[11]});
		host.acc(1'b1, 8'h1B, 8'h2A);
		cmp(num, {v[6][5:0], v[7], v[8]});
		host.num(22'h2A5A5A);
		cmp(num, 22'h2A5A5A);
		$display("end of test fields");
		// Every select code, with and without powerdown.
		for (int s = 0; s < 8; s++) begin
			host.acc(1'b1, 8'h15, {s[2], 5'h00, s[1:0]});
			cmp({tri_s, pecl, lvds, hcsl}, s[2] ? 4'h8 : 4'h8 >> s[1:0]);
			cmp(pd, s[2]);
		end
		$display("end of test driver");
		// Mid-run reset, then the bypassed reference and the smallest valid output divider.
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		cmp(num, 22'h1CB3E3);
		cmp(odiv, 9'h04E);
		host.acc(1'b1, SODR_ADDR_REFERENCE_DIVIDER_CONTROL, 8'h00);
		host.acc(1'b1, SODR_ADDR_OUTPUT_DIVIDER_LOW, 8'h05);
		o0 = n_out;
		p0 = n_pfd;
		vco_tick = 1'b1;
		ref_tick = 1'b1;
		repeat (20) @(negedge clk_sys);
		vco_tick = 1'b0;
		ref_tick = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp(n_pfd - p0, 20);
		cmp(n_out - o0, 4);
		$display("end of test bypass");
		repeat (2) @(negedge clk_sys);
		results();
	end
endmodule
bind sodr_regs sodr_regs_asserts u_chk(.clk_sys, .rst_n, .reg_wr, .reg_addr, .reg_wdata,
	.output_buffer_powerdown, .driver_select, .out_lvds_en, .output_divider_value, .reference_div4_enable,
	.feedback_integer_value, .fraction_numerator, .fraction_denominator);
`default_nettype wire
